// ### shared/tcsrc_pkg.sv
// Package for the Type-C source status and control block
package tcsrc_pkg;

  // Register byte offsets
  localparam logic [7:0] TCSRC_REG_STATUS = 8'h00;
  localparam logic [7:0] TCSRC_REG_CTRL = 8'h04;
  localparam logic [7:0] TCSRC_REG_CC = 8'h08;

  // Status register bit positions
  localparam int TCSRC_ST_ATTACH = 0;
  localparam int TCSRC_ST_VBUS_GOOD = 1;
  localparam int TCSRC_ST_FLIP = 2;
  localparam int TCSRC_ST_PWR_EN = 3;
  localparam int TCSRC_ST_ACC = 4;
  localparam int TCSRC_ST_SINK = 5;
  localparam int TCSRC_ST_STATE_LSB = 8;

  // Control register bit positions and reset value
  localparam int TCSRC_CT_UNDERVOLT_LOCKOUT_EN = 0;
  localparam int TCSRC_CT_OVERVOLT_LOCKOUT_EN = 1;
  localparam int TCSRC_CT_PSUP_EN = 2;
  localparam logic [31:0] TCSRC_CTRL_RESET = 32'h0000_0004;

  // Debounce time on a settled configuration channel
  localparam int TCSRC_CLK_MHZ = 125;
  localparam int TCSRC_DEB_US = 2;
  localparam int TCSRC_DEB_CYC = TCSRC_DEB_US * TCSRC_CLK_MHZ;

  // AXI response codes
  localparam logic [1:0] TCSRC_RESP_OKAY = 2'b00;
  localparam logic [1:0] TCSRC_RESP_SLVERR = 2'b10;

  // Detected level of one configuration channel pin
  typedef enum logic [1:0] {
    TCSRC_CC_OPEN,
    TCSRC_CC_RD,
    TCSRC_CC_RA
  } tcsrc_cc_t;

  // Advertised termination
  typedef enum logic [1:0] {
    TCSRC_RP_DEFAULT,
    TCSRC_RP_1A5,
    TCSRC_RP_3A0
  } tcsrc_rp_t;

  // Connection states
  typedef enum logic [2:0] {
    TCSRC_UNATTACHED,
    TCSRC_ATTACH_WAIT,
    TCSRC_ATTACHED,
    TCSRC_AUDIO_ACC,
    TCSRC_DEBUG_ACC,
    TCSRC_ERROR_RECOV
  } tcsrc_state_t;

  // Open-drain indicator bundle, each pulled low when asserted
  typedef struct packed {
    logic link_made;
    logic accessory_found;
    logic plug_flip;
    logic bus_voltage_good;
    logic bus_power_enable;
  } tcsrc_ind_t;

endpackage

// ### rtl/tcsrc_sync.sv
// Two-stage synchroniser for a bundle of level inputs
`timescale 1ns/1ps
`default_nettype none
module tcsrc_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // tcsrc_sync
`default_nettype wire

// ### rtl/tcsrc_top.sv
// Type-C source connection logic with open-drain indicators and AXI4-Lite status
// Function
// - Reset input is active high
// - Indicators are active-low open drain
// - Voltage good only attached with bus valid
// - Voltage good mirrored in status bit
// - Link indicator on valid sink connection
// - Link indicator also for accessory
// - Attachment mirrored in status bit
// - Default select low gives default termination
// - Default high, high low gives 1.5 A
// - Both high gives 3.0 A
// - Selects may change any time, tracked
// - Accessory indicator for audio or debug
// - Flip floats on channel a, low on b
// - Orientation readable in status register
// - Power enable needs sink and bus valid
// - Power enable value in status bit
// - Plug supply to unused channel pin
// - Supply lockouts gate power enable when enabled
// - Source connection machine with accessory support
// - Transitions from channel states and bus voltage
// - Partner classed sink or accessory
`timescale 1ns/1ps
`default_nettype none
module tcsrc_top
  import tcsrc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Termination selects
  input wire logic pullup_default_sel,
  input wire logic pullup_high_current_sel,
  // Detected channel levels and bus sensing
  input wire tcsrc_cc_t config_channel_a,
  input wire tcsrc_cc_t config_channel_b,
  input wire logic bus_voltage_sense,
  input wire logic bus_voltage_in_range,
  input wire logic undervolt_lockout,
  input wire logic overvolt_lockout,
  // Termination and plug supply control
  output tcsrc_rp_t pullup_level,
  output logic plug_supply_to_a,
  output logic plug_supply_to_b,
  // Open-drain indicator outputs
  output tcsrc_ind_t ind_out,
  output tcsrc_ind_t ind_oe,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  tcsrc_state_t state_ff, nxt_state;
  logic [8:0] deb_cnt_ff, nxt_deb_cnt;
  logic flip_ff, nxt_flip;
  logic [31:0] ctrl_ff;
  tcsrc_rp_t rp_ff;
  tcsrc_ind_t ind_ff, nxt_ind;
  logic psup_a_ff, psup_b_ff;
  logic [1:0] sel_sync;
  logic [7:0] awaddr_ff;
  logic aw_held_ff, w_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [3:0] cc_last_ff;

  localparam logic [8:0] DEB_LAST = 9'(TCSRC_DEB_CYC - 1);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] din,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = din[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Register map hit, shared by write and read paths
  function automatic logic reg_known(input logic [7:0] addr);
    return (addr == TCSRC_REG_STATUS) || (addr == TCSRC_REG_CTRL) || (addr == TCSRC_REG_CC);
  endfunction

  // Both channel levels packed as one code
  function automatic logic [3:0] cc_code(input tcsrc_cc_t a, input tcsrc_cc_t b);
    return {2'(b), 2'(a)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Termination select

  tcsrc_sync #(.WIDTH(2)) u_sel_sync (
    .clock(clock),
    .reset(reset),
    .async_in({pullup_default_sel, pullup_high_current_sel}),
    .sync_out(sel_sync)
  );

  wire tcsrc_rp_t nxt_rp = !sel_sync[1] ? TCSRC_RP_DEFAULT :
                           !sel_sync[0] ? TCSRC_RP_1A5 :
                           TCSRC_RP_3A0;

  ////////////////////////////////////////////////////////////////////////////
  // Channel decode and voltage conditions

  wire logic a_rd = (config_channel_a == TCSRC_CC_RD);
  wire logic b_rd = (config_channel_b == TCSRC_CC_RD);
  wire logic a_ra = (config_channel_a == TCSRC_CC_RA);
  wire logic b_ra = (config_channel_b == TCSRC_CC_RA);
  wire logic sink_seen = a_rd ^ b_rd;
  wire logic audio_seen = a_ra && b_ra;
  wire logic debug_seen = a_rd && b_rd;
  wire logic none_seen = !(a_rd || b_rd || audio_seen);
  wire logic bus_ok = bus_voltage_sense && bus_voltage_in_range;
  wire logic supply_ok = !(ctrl_ff[TCSRC_CT_UNDERVOLT_LOCKOUT_EN] && undervolt_lockout) &&
                         !(ctrl_ff[TCSRC_CT_OVERVOLT_LOCKOUT_EN] && overvolt_lockout);
  wire logic deb_done = (deb_cnt_ff == DEB_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Channel change tracking

  // Debounce restarts whenever either pin level moves
  wire logic [3:0] cc_now = cc_code(config_channel_a, config_channel_b);
  wire logic cc_moved = (cc_now != cc_last_ff);
  wire logic in_sink = (state_ff == TCSRC_ATTACHED);
  wire logic in_acc = (state_ff == TCSRC_AUDIO_ACC) || (state_ff == TCSRC_DEBUG_ACC);

  ////////////////////////////////////////////////////////////////////////////
  // Connection state machine

  always_comb begin
    nxt_state = state_ff;
    nxt_deb_cnt = 9'h000;
    nxt_flip = flip_ff;
    unique case (state_ff)
      TCSRC_UNATTACHED: begin
        if (!none_seen) begin
          nxt_state = TCSRC_ATTACH_WAIT;
        end
      end
      TCSRC_ATTACH_WAIT: begin
        if (none_seen) begin
          nxt_state = TCSRC_UNATTACHED;
        end else if (cc_moved) begin
          nxt_deb_cnt = 9'h000;
        end else if (!deb_done) begin
          nxt_deb_cnt = deb_cnt_ff + 9'h001;
        end else if (audio_seen) begin
          nxt_state = TCSRC_AUDIO_ACC;
        end else if (debug_seen) begin
          nxt_state = TCSRC_DEBUG_ACC;
        end else if (sink_seen && !bus_voltage_sense) begin
          nxt_state = TCSRC_ATTACHED;
          nxt_flip = b_rd;
        end else begin
          nxt_deb_cnt = deb_cnt_ff;
        end
      end
      TCSRC_ATTACHED: begin
        if (!sink_seen) begin
          nxt_state = TCSRC_UNATTACHED;
        end else if (ind_ff.bus_power_enable && !bus_ok) begin
          nxt_state = TCSRC_ERROR_RECOV;
        end
      end
      TCSRC_AUDIO_ACC: begin
        if (!audio_seen) begin
          nxt_state = TCSRC_UNATTACHED;
        end
      end
      TCSRC_DEBUG_ACC: begin
        if (!debug_seen) begin
          nxt_state = TCSRC_UNATTACHED;
        end
      end
      TCSRC_ERROR_RECOV: begin
        if (!deb_done) begin
          nxt_deb_cnt = deb_cnt_ff + 9'h001;
        end else begin
          nxt_state = TCSRC_UNATTACHED;
        end
      end
      default: begin
        nxt_state = TCSRC_UNATTACHED;
      end
    endcase
  end

  always_comb begin
    nxt_ind.link_made = in_sink || in_acc;
    nxt_ind.accessory_found = in_acc;
    nxt_ind.plug_flip = in_sink && flip_ff;
    nxt_ind.bus_voltage_good = in_sink && bus_ok;
    nxt_ind.bus_power_enable = in_sink && bus_ok && supply_ok;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= TCSRC_UNATTACHED;
      deb_cnt_ff <= 9'h000;
      flip_ff <= 1'b0;
      ind_ff <= '0;
      rp_ff <= TCSRC_RP_DEFAULT;
      psup_a_ff <= 1'b0;
      psup_b_ff <= 1'b0;
      cc_last_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      deb_cnt_ff <= nxt_deb_cnt;
      flip_ff <= nxt_flip;
      ind_ff <= nxt_ind;
      rp_ff <= nxt_rp;
      psup_a_ff <= in_sink && ctrl_ff[TCSRC_CT_PSUP_EN] && flip_ff;
      psup_b_ff <= in_sink && ctrl_ff[TCSRC_CT_PSUP_EN] && !flip_ff;
      cc_last_ff <= cc_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs

  assign pullup_level = rp_ff;
  assign plug_supply_to_a = psup_a_ff;
  assign plug_supply_to_b = psup_b_ff;
  assign ind_out = '0;
  assign ind_oe = ind_ff;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  wire logic [31:0] status_word = {16'h0000, 5'h00, 3'(state_ff), 2'b00,
                                   in_sink,
                                   ind_ff.accessory_found,
                                   ind_ff.bus_power_enable,
                                   flip_ff,
                                   ind_ff.bus_voltage_good,
                                   ind_ff.link_made};
  wire logic [31:0] cc_word = {24'h00_0000, 2'b00, 2'(rp_ff), cc_code(config_channel_a, config_channel_b)};
  wire logic wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  wire logic wr_ctrl = (awaddr_ff == TCSRC_REG_CTRL);
  wire logic wr_ok = reg_known(awaddr_ff);
  wire logic rd_take = s_axi_arvalid && !rvalid_ff;
  wire logic [31:0] rd_word = (s_axi_araddr == TCSRC_REG_STATUS) ? status_word :
                              (s_axi_araddr == TCSRC_REG_CTRL) ? ctrl_ff :
                              (s_axi_araddr == TCSRC_REG_CC) ? cc_word : 32'h0000_0000;
  wire logic rd_hit = reg_known(s_axi_araddr);

  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready = !w_held_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge clock) begin
    if (reset) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= TCSRC_RESP_OKAY;
      ctrl_ff <= TCSRC_CTRL_RESET;
    end else begin
      if (s_axi_awvalid && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? TCSRC_RESP_OKAY : TCSRC_RESP_SLVERR;
        if (wr_ctrl) begin
          ctrl_ff <= merge_bytes(ctrl_ff, wdata_ff, wstrb_ff) & 32'h0000_0007;
        end
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= TCSRC_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_hit ? TCSRC_RESP_OKAY : TCSRC_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule // tcsrc_top
`default_nettype wire

// ### testbench/tcsrc_checker.sv
// Port assertions for the Type-C source status block
`timescale 1ns/1ps
`default_nettype none
module tcsrc_checker
  import tcsrc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Termination
  input wire logic pullup_default_sel,
  input wire logic pullup_high_current_sel,
  input wire tcsrc_rp_t pullup_level,
  // Plug supply and indicators
  input wire logic plug_supply_to_a,
  input wire logic plug_supply_to_b,
  input wire tcsrc_ind_t ind_out,
  input wire tcsrc_ind_t ind_oe,
  // Bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_rd_req;
    s_axi_arvalid && !s_axi_rvalid;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence s_r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  AST_RST_REL: assert property ($fell(reset) |-> ind_oe == '0 && pullup_level == TCSRC_RP_DEFAULT)
    else $error("state after reset wrong");
  AST_OD_DATA: assert property (ind_out == '0)
    else $error("open drain data not low");
  AST_VGOOD: assert property (ind_oe.bus_voltage_good |-> ind_oe.link_made)
    else $error("voltage good while detached");
  AST_ACC: assert property (ind_oe.accessory_found |-> ind_oe.link_made)
    else $error("accessory without link");
  AST_PWR: assert property (ind_oe.bus_power_enable |-> ind_oe.link_made && !ind_oe.accessory_found)
    else $error("power enable without sink");
  AST_PULLUP: assert property (!$past(reset, 1) && !$past(reset, 2) && !$past(reset, 3) |->
    pullup_level == (!$past(pullup_default_sel, 3) ? TCSRC_RP_DEFAULT :
    $past(pullup_high_current_sel, 3) ? TCSRC_RP_3A0 : TCSRC_RP_1A5))
    else $error("pullup level wrong");
  AST_PSUP: assert property (!(plug_supply_to_a && plug_supply_to_b))
    else $error("plug supply on both pins");
  AST_B_HOLD: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_NEXT: assert property (s_rd_req |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // tcsrc_checker
bind tcsrc_top tcsrc_checker i_tcsrc_checker (.clock, .reset, .pullup_default_sel, .pullup_high_current_sel,
  .pullup_level, .plug_supply_to_a, .plug_supply_to_b, .ind_out, .ind_oe, .s_axi_arvalid, .s_axi_bready,
  .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_rdata, .s_axi_rvalid);
`default_nettype wire

// ### testbench/tcsrc_sink_model.sv
// Cable partner: sink on either pin, audio or debug accessory
`timescale 1ns/1ps
`default_nettype none
module tcsrc_sink_model
  import tcsrc_pkg::*;
(
  // Kind: 0 none, 1 sink a, 2 sink b, 3 audio, 4 debug
  input wire logic [2:0] kind,
  // Channel levels
  output tcsrc_cc_t cc_a,
  output tcsrc_cc_t cc_b
);
  assign cc_a = (kind == 3'd1 || kind == 3'd4) ? TCSRC_CC_RD : (kind == 3'd3) ? TCSRC_CC_RA : TCSRC_CC_OPEN;
  assign cc_b = (kind == 3'd2 || kind == 3'd4) ? TCSRC_CC_RD : (kind == 3'd3) ? TCSRC_CC_RA : TCSRC_CC_OPEN;
endmodule // tcsrc_sink_model
`default_nettype wire

// ### testbench/test_tcsrc_top.sv
// Register and indicator tests of the source status block
`timescale 1ns/1ps
`default_nettype none
module test_tcsrc_top;
  import tcsrc_pkg::*;
  logic clock = 0, reset = 1, def_sel = 0, hi_sel = 0, sense = 0, in_range = 0, uv = 0, ov = 0;
  logic [2:0] kind = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pa, pb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  tcsrc_cc_t cc_a, cc_b;
  tcsrc_rp_t pullup_level;
  tcsrc_ind_t ind_out, ind_oe;
  int error_cnt = 0, compares = 0, i;
  tcsrc_sink_model i_tcsrc_sink_model (.kind(kind), .cc_a(cc_a), .cc_b(cc_b));
  tcsrc_top i_tcsrc_top (.clock(clock), .reset(reset), .pullup_default_sel(def_sel),
    .pullup_high_current_sel(hi_sel), .config_channel_a(cc_a), .config_channel_b(cc_b),
    .bus_voltage_sense(sense), .bus_voltage_in_range(in_range), .undervolt_lockout(uv),
    .overvolt_lockout(ov), .pullup_level(pullup_level), .plug_supply_to_a(pa), .plug_supply_to_b(pb),
    .ind_out(ind_out), .ind_oe(ind_oe), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  initial begin
    forever #4 clock = ~clock;
  end
  task automatic complete_run();
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // One AXI4-Lite transfer, write when we is high
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic done, haw, hw, har;
    int n;
    done = 0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= we;
    s_axi_wvalid <= we;
    s_axi_bready <= we;
    s_axi_arvalid <= !we;
    s_axi_rready <= !we;
    while (!done && n < 40) begin
      #1;
      haw = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      har = s_axi_arvalid && s_axi_arready;
      done = we ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = we ? s_axi_bresp : s_axi_rresp;
      @(posedge clock);
      n++;
      if (haw) s_axi_awvalid <= 0;
      if (hw) s_axi_wvalid <= 0;
      if (har) s_axi_arvalid <= 0;
    end
    s_axi_bready <= 0;
    s_axi_rready <= 0;
    #1;
    if (!done) begin
      error_cnt++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1, a, d);
    chk("bresp", {30'h0, TCSRC_RESP_OKAY}, {30'h0, r});
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(0, a, 0);
    chk(nm, e, q & m);
  endtask
  task automatic pwr(input logic e);
    tick(6);
    chk("power", {31'h0, e}, {31'h0, ind_oe.bus_power_enable});
  endtask
  initial begin
    tick(5);
    reset <= 0;
    tick(1);
    chk("ind reset", 0, ind_oe);
    rd("ctrl", TCSRC_REG_CTRL, 32'hffff_ffff, TCSRC_CTRL_RESET);
    rd("status", TCSRC_REG_STATUS, 32'hffff_ffff, 32'h0000_0000);
    bus(0, 8'h0c, 0);
    chk("slverr", {30'h0, TCSRC_RESP_SLVERR}, {30'h0, r});
    chk("unmapped", 0, q);
    bus(1, 8'h0c, 0);
    chk("wr slverr", {30'h0, TCSRC_RESP_SLVERR}, {30'h0, r});
    for (i = 0; i < 4; i++) begin
      def_sel <= i[1];
      hi_sel <= i[0];
      tick(5);
      chk("pullup", (i < 2) ? 0 : i - 1, pullup_level);
      rd("cc pullup", TCSRC_REG_CC, 32'h0000_0030, ((i < 2) ? 0 : i - 1) << 4);
    end
    for (i = 0; i < 2; i++) begin
      kind <= i + 1;
      tick(300);
      chk("ind link", {27'h0, 1'b1, 1'b0, i[0], 2'b00}, ind_oe);
      chk("plug supply", i[0] ? 2 : 1, {pa, pb});
      sense <= 1;
      in_range <= 1;
      tick(6);
      chk("ind power", {27'h0, 1'b1, 1'b0, i[0], 2'b11}, ind_oe);
      rd("status sink", TCSRC_REG_STATUS, 32'h0000_07ff, 32'h0000_022b | (i << 2));
      wr(TCSRC_REG_CTRL, 32'h0000_0005);
      uv <= 1;
      pwr(0);
      uv <= 0;
      pwr(1);
      wr(TCSRC_REG_CTRL, 32'h0000_0004);
      ov <= 1;
      pwr(1);
      wr(TCSRC_REG_CTRL, 32'h0000_0006);
      pwr(0);
      ov <= 0;
      wr(TCSRC_REG_CTRL, 32'h0000_0004);
      in_range <= 0;
      tick(3);
      chk("ind recov", 0, ind_oe);
      rd("status recov", TCSRC_REG_STATUS, 32'h0000_0700, 32'h0000_0500);
      kind <= 0;
      sense <= 0;
      in_range <= 0;
      tick(600);
      chk("ind detach", 0, ind_oe);
    end
    for (i = 3; i < 5; i++) begin
      kind <= i;
      tick(300);
      chk("link acc", 1, ind_oe.link_made);
      chk("acc found", 1, ind_oe.accessory_found);
      if (i == 3) chk("acc power", 0, ind_oe.bus_power_enable);
      rd("status acc", TCSRC_REG_STATUS, 32'h0000_0711, 32'h0000_0011 | (i << 8));
      kind <= 0;
      tick(600);
    end
    complete_run();
  end
endmodule // test_tcsrc_top
`default_nettype wire
